// ==== hw/field_port_defs.vh ====
// constants for the field memory port of the deinterlacer
// assumes a 32-bit memory master and one system clock
`ifndef FIELD_PORT_DEFS_VH
`define FIELD_PORT_DEFS_VH

// memory master burst shape
`define BURST_BEATS 7'h20
`define AXLEN_FIXED 8'h1f
`define AXSIZE_WORD 3'h2
`define AXBURST_INCR 2'h1
`define WSTRB_ALL 4'hf
`define BURST_BYTES 32'h0000_0080
`define LAST_BEAT 5'h1f

// read stream identities and limits
`define RID_PREV1 1'h0
`define RID_PREV2 1'h1
`define RD_PEND_MAX 2'h2
`define RBUF_WORDS 7'h40

// write buffer
`define WFIFO_WORDS 7'h40

// packing of pixel and motion-error pairs
`define PAIR_BITS_NARROW 7'h28
`define PAIR_BITS_WIDE 7'h30
`define WORD_BITS 7'h20

// chroma formats
`define FMT_420 2'h0
`define FMT_422 2'h1
`define FMT_444 2'h2

// field buffer rotation
`define BUF_LAST 2'h2
`define BUF_FIRST 2'h0

// output credit per accepted input pixel
`define OUT_PER_IN 4'h2

`endif

// ==== hw/two_slot_buffer.v ====
// two-entry valid/ready buffer for the output word path
// assumes both sides run on the same clock
`timescale 1ns/1ps
`default_nettype none
module two_slot_buffer #(
	parameter WIDTH = 34
) (
	// clock and reset
	input wire clock,
	input wire sys_rst,
	input wire clear,
	// filling side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// draining side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] slot0;
	reg [WIDTH-1:0] slot1;
	reg [1:0] fill;
	wire push;
	wire pop;

	// full and empty come straight from the fill count
	assign in_ready = (fill != 2'h2);
	assign out_valid = (fill != 2'h0);
	assign out_data = slot0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// slot0 is the head; slot1 holds the word behind it
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			slot0 <= {WIDTH{1'b0}};
			slot1 <= {WIDTH{1'b0}};
			fill <= 2'h0;
		end else if (clear) begin
			fill <= 2'h0;
		end else begin
			if (pop && push) begin
				if (fill == 2'h1)
					slot0 <= in_data;
				else begin
					slot0 <= slot1;
					slot1 <= in_data;
				end
			end else if (pop) begin
				slot0 <= slot1;
				fill <= fill - 2'h1;
			end else if (push) begin
				if (fill == 2'h0)
					slot0 <= in_data;
				else
					slot1 <= in_data;
				fill <= fill + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== hw/field_memory_port.v ====
// field memory port: packs video pairs, writes and reads the triple field store
// assumes a 32-bit memory master, a pixel clock sampled as a plain input,
// and software settings arriving on quasi-static pins
`timescale 1ns/1ps
`default_nettype none
`include "field_port_defs.vh"

// What this block does and what it relies on
// RULE1: write bursts are always 32 beats
// RULE2: words packed back to back, full width
// RULE3: write address only with full burst buffered
// RULE4: one write transaction outstanding at most
// RULE5: read only when whole burst fits
// RULE6: read data ready held high always
// RULE7: read bursts are 32 full-width beats
// RULE8: read streams use fixed ids 0, 1
// RULE9: memory returns request id with data
// RULE10: read data steered by its id
// RULE11: two reads pending per id, four total
// RULE12: controller accepts ids and four pending reads
// RULE13: start flag marks only first pixel
// RULE14: source blanking at least one clock
// RULE15: blanking data on input is dropped
// RULE16: output pixel rate twice input rate
// RULE17: input ready held high always
// RULE18: source valid averages at most half
// RULE19: progressive output framed with blanking strobes
// RULE20: chroma 4:2:0, 4:2:2, 4:4:4 selectable
// RULE21: video, control, memory domains kept distinct
// RULE22: each domain has own low reset
// RULE23: pairs packed five words per four, three per two
// RULE24: write current field, read two older
// RULE25: bases rotate at each output frame end
// RULE26: bursts ascend contiguously from buffer base
module field_memory_port (
	// clock and resets
	input wire clock,
	input wire sys_rst,
	input wire video_rst_n,
	input wire ctrl_rst_n,
	input wire mem_rst_n,
	// video input
	input wire pix_clk,
	input wire [47:0] s_tdata,
	input wire s_tvalid,
	output wire s_tready,
	input wire s_tuser,
	input wire in_active,
	// video output
	output wire [31:0] m_tdata,
	output wire m_tvalid,
	input wire m_tready,
	output wire m_tuser,
	output wire m_tlast,
	output reg hblank,
	output reg vblank,
	// settings
	input wire deint_en,
	input wire [1:0] chroma_fmt,
	input wire depth_12,
	input wire [11:0] out_line_len,
	input wire [11:0] out_lines,
	input wire [95:0] buf_bases,
	// memory write channels
	output reg [31:0] m_axi_awaddr,
	output wire [7:0] m_axi_awlen,
	output wire [2:0] m_axi_awsize,
	output wire [1:0] m_axi_awburst,
	output wire m_axi_awvalid,
	input wire m_axi_awready,
	output wire [31:0] m_axi_wdata,
	output wire [3:0] m_axi_wstrb,
	output wire m_axi_wlast,
	output wire m_axi_wvalid,
	input wire m_axi_wready,
	input wire [1:0] m_axi_bresp,
	input wire m_axi_bvalid,
	output wire m_axi_bready,
	// memory read channels
	output reg [31:0] m_axi_araddr,
	output wire [7:0] m_axi_arlen,
	output wire [2:0] m_axi_arsize,
	output wire [1:0] m_axi_arburst,
	output reg m_axi_arid,
	output reg m_axi_arvalid,
	input wire m_axi_arready,
	input wire [31:0] m_axi_rdata,
	input wire m_axi_rid,
	input wire m_axi_rlast,
	input wire m_axi_rvalid,
	output wire m_axi_rready
);
	localparam W_IDLE = 4'h1;
	localparam W_ADDR = 4'h2;
	localparam W_DATA = 4'h4;
	localparam W_RESP = 4'h8;

	// per-domain resets, each through two flip-flops
	reg [1:0] vid_rs;
	reg [1:0] ctl_rs;
	reg [1:0] mem_rs;
	wire vid_clr = ~vid_rs[1];
	wire ctl_clr = ~ctl_rs[1];
	wire mem_clr = ~mem_rs[1];
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			vid_rs <= 2'h0;
			ctl_rs <= 2'h0;
			mem_rs <= 2'h0;
		end else begin
			vid_rs <= {vid_rs[0], video_rst_n}; // RULE22
			ctl_rs <= {ctl_rs[0], ctrl_rst_n}; // RULE22
			mem_rs <= {mem_rs[0], mem_rst_n}; // RULE22
		end
	end

	// settings pins cross in through two flip-flops under the control reset
	reg [123:0] cfg_s1;
	reg [123:0] cfg_s2;
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_s1 <= {124{1'b0}};
			cfg_s2 <= {124{1'b0}};
		end else if (ctl_clr) begin // RULE21
			cfg_s1 <= {124{1'b0}};
			cfg_s2 <= {124{1'b0}};
		end else begin
			cfg_s1 <= {deint_en, chroma_fmt, depth_12, out_line_len, out_lines, buf_bases};
			cfg_s2 <= cfg_s1;
		end
	end
	wire en = cfg_s2[123];
	wire [1:0] fmt = cfg_s2[122:121];
	wire wide = cfg_s2[120];
	wire [11:0] line_len = cfg_s2[119:108];
	wire [11:0] lines = cfg_s2[107:96];
	wire [95:0] bases = cfg_s2[95:0];

	// video pins through two flip-flops; a falling pixel clock edge marks stable data
	reg [51:0] vin_s1;
	reg [51:0] vin_s2;
	reg pclk_d;
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			vin_s1 <= {52{1'b0}};
			vin_s2 <= {52{1'b0}};
			pclk_d <= 1'b0;
		end else begin
			vin_s1 <= {pix_clk, in_active, s_tuser, s_tvalid, s_tdata};
			vin_s2 <= vin_s1;
			pclk_d <= vin_s2[51];
		end
	end
	wire tick = pclk_d && !vin_s2[51];
	assign s_tready = 1'b1; // RULE17

	// pixel acceptance: nothing before the first start flag, no blanking words
	reg in_frame;
	wire take_raw = tick && vin_s2[48] && vin_s2[50]; // RULE15
	wire take = take_raw && (in_frame || vin_s2[49]);
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			in_frame <= 1'b0;
		else if (vid_clr)
			in_frame <= 1'b0;
		else if (take_raw && vin_s2[49])
			in_frame <= 1'b1; // RULE13
	end

	// bit packer: pairs enter LSB first, whole words leave with no gaps
	reg [79:0] acc;
	reg [6:0] acc_n;
	reg [79:0] next_acc;
	reg [6:0] next_acc_n;
	reg [6:0] base_n;
	wire [6:0] wf_cnt;
	wire pk_emit = (acc_n >= `WORD_BITS) && (wf_cnt != `WFIFO_WORDS);
	wire [6:0] pair_bits = wide ? `PAIR_BITS_WIDE : `PAIR_BITS_NARROW; // RULE23
	wire [47:0] pair = wide ? vin_s2[47:0] : {8'h00, vin_s2[39:0]};
	always @* begin
		next_acc = pk_emit ? {32'h0000_0000, acc[79:32]} : acc; // RULE2
		base_n = pk_emit ? (acc_n - `WORD_BITS) : acc_n;
		next_acc_n = base_n;
		if (take) begin
			next_acc = next_acc | ({32'h0000_0000, pair} << base_n); // RULE23
			next_acc_n = base_n + pair_bits;
		end
	end
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			acc <= {80{1'b0}};
			acc_n <= 7'h00;
		end else if (vid_clr) begin
			acc <= {80{1'b0}};
			acc_n <= 7'h00;
		end else begin
			acc <= next_acc;
			acc_n <= next_acc_n;
		end
	end

	// write word buffer feeding the write channel
	reg [31:0] wf_mem [0:63];
	reg [5:0] wf_wp;
	reg [5:0] wf_rp;
	reg [6:0] wf_fill;
	wire wf_pop = m_axi_wvalid && m_axi_wready;
	assign wf_cnt = wf_fill;
	assign m_axi_wdata = wf_mem[wf_rp];
	always @(posedge clock) begin
		if (pk_emit)
			wf_mem[wf_wp] <= acc[31:0];
	end
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wf_wp <= 6'h00;
			wf_rp <= 6'h00;
			wf_fill <= 7'h00;
		end else if (mem_clr) begin
			wf_wp <= 6'h00;
			wf_rp <= 6'h00;
			wf_fill <= 7'h00;
		end else begin
			if (pk_emit)
				wf_wp <= wf_wp + 6'h01;
			if (wf_pop)
				wf_rp <= wf_rp + 6'h01;
			wf_fill <= wf_fill + {6'h00, pk_emit} - {6'h00, wf_pop};
		end
	end

	// field buffer selection: write to one, read the two older ones
	reg [1:0] wr_sel;
	reg rot_pend;
	wire rot_req;
	function [1:0] step3;
		input [1:0] v;
		begin
			step3 = (v == `BUF_LAST) ? `BUF_FIRST : v + 2'h1;
		end
	endfunction
	wire [1:0] sel_prev1 = step3(step3(wr_sel)); // RULE24
	wire [1:0] sel_prev2 = step3(wr_sel); // RULE24

	// write engine: one burst at a time, started only with a burst in hand
	reg [3:0] wstate;
	reg [4:0] wbeat;
	reg [31:0] wr_off;
	wire [1:0] rd_pend0;
	wire [1:0] rd_pend1;
	wire rd_idle = (rd_pend0 == 2'h0) && (rd_pend1 == 2'h0) && !m_axi_arvalid;
	wire rot_now = rot_pend && (wstate == W_IDLE) && rd_idle;
	assign m_axi_awvalid = (wstate == W_ADDR);
	assign m_axi_awlen = `AXLEN_FIXED; // RULE1
	assign m_axi_awsize = `AXSIZE_WORD; // RULE2
	assign m_axi_awburst = `AXBURST_INCR;
	assign m_axi_wvalid = (wstate == W_DATA);
	assign m_axi_wstrb = `WSTRB_ALL; // RULE2
	assign m_axi_wlast = (wbeat == `LAST_BEAT); // RULE1
	assign m_axi_bready = 1'b1;
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wstate <= W_IDLE;
			wbeat <= 5'h00;
			wr_off <= 32'h0000_0000;
			wr_sel <= `BUF_FIRST;
			rot_pend <= 1'b0;
			m_axi_awaddr <= 32'h0000_0000;
		end else if (mem_clr) begin
			wstate <= W_IDLE;
			wbeat <= 5'h00;
			wr_off <= 32'h0000_0000;
			wr_sel <= `BUF_FIRST;
			rot_pend <= 1'b0;
		end else begin
			if (rot_req)
				rot_pend <= 1'b1;
			else if (rot_now)
				rot_pend <= 1'b0;
			if (rot_now) begin
				wr_sel <= step3(wr_sel); // RULE25
				wr_off <= 32'h0000_0000; // RULE25
			end
			case (wstate)
			W_IDLE: begin
				if (!rot_pend && wf_fill >= `BURST_BEATS) begin // RULE3
					m_axi_awaddr <= bases[wr_sel*32 +: 32] + wr_off; // RULE26
					wstate <= W_ADDR;
				end
			end
			W_ADDR: begin
				if (m_axi_awready) begin
					wbeat <= 5'h00;
					wstate <= W_DATA;
				end
			end
			W_DATA: begin
				if (m_axi_wready) begin
					wbeat <= wbeat + 5'h01;
					if (m_axi_wlast) begin
						wr_off <= wr_off + `BURST_BYTES; // RULE26
						wstate <= W_RESP;
					end
				end
			end
			W_RESP: begin
				if (m_axi_bvalid)
					wstate <= W_IDLE; // RULE4
			end
			default: wstate <= W_IDLE;
			endcase
		end
	end

	// read streams: per id a landing buffer, pending count and address offset
	wire [1:0] want;
	wire [1:0] pop_rd;
	wire [1:0] pend_bus [0:1];
	wire [31:0] rd_addr [0:1];
	wire [31:0] rd_word [0:1];
	wire [1:0] has_word;
	wire [1:0] ar_issue;
	assign rd_pend0 = pend_bus[0];
	assign rd_pend1 = pend_bus[1];
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : rd_stream
			reg [31:0] rb_mem [0:63];
			reg [5:0] rb_wp;
			reg [5:0] rb_rp;
			reg [6:0] rb_fill;
			reg [1:0] pend;
			reg [31:0] off;
			wire push = m_axi_rvalid && (m_axi_rid == gi); // RULE10
			wire [8:0] need = {2'h0, rb_fill} + {2'h0, pend, 5'h00} + {2'h0, `BURST_BEATS};
			assign want[gi] = en && !rot_pend && (pend != `RD_PEND_MAX) && (need <= {2'h0, `RBUF_WORDS}); // RULE5 RULE11
			assign pend_bus[gi] = pend;
			assign rd_addr[gi] = bases[(gi == 0 ? sel_prev1 : sel_prev2)*32 +: 32] + off; // RULE26
			assign rd_word[gi] = rb_mem[rb_rp];
			assign has_word[gi] = (rb_fill != 7'h00);
			always @(posedge clock) begin
				if (push)
					rb_mem[rb_wp] <= m_axi_rdata;
			end
			always @(posedge clock or posedge sys_rst) begin
				if (sys_rst) begin
					rb_wp <= 6'h00;
					rb_rp <= 6'h00;
					rb_fill <= 7'h00;
					pend <= 2'h0;
					off <= 32'h0000_0000;
				end else if (mem_clr) begin
					rb_wp <= 6'h00;
					rb_rp <= 6'h00;
					rb_fill <= 7'h00;
					pend <= 2'h0;
					off <= 32'h0000_0000;
				end else begin
					if (push)
						rb_wp <= rb_wp + 6'h01;
					if (pop_rd[gi])
						rb_rp <= rb_rp + 6'h01;
					rb_fill <= rb_fill + {6'h00, push} - {6'h00, pop_rd[gi]};
					// a burst holds its room from issue until its last beat lands
					pend <= pend + {1'b0, ar_issue[gi]} - {1'b0, push && m_axi_rlast};
					if (rot_now)
						off <= 32'h0000_0000; // RULE25
					else if (ar_issue[gi])
						off <= off + `BURST_BYTES; // RULE26
				end
			end
		end
	endgenerate

	// read address issue, alternating between the two ids
	reg rr_last;
	wire pick1 = want[1] && (!want[0] || !rr_last);
	assign ar_issue[0] = !m_axi_arvalid && want[0] && !pick1;
	assign ar_issue[1] = !m_axi_arvalid && pick1;
	assign m_axi_arlen = `AXLEN_FIXED; // RULE7
	assign m_axi_arsize = `AXSIZE_WORD; // RULE7
	assign m_axi_arburst = `AXBURST_INCR;
	assign m_axi_rready = 1'b1; // RULE6
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			m_axi_arvalid <= 1'b0;
			m_axi_arid <= `RID_PREV1;
			m_axi_araddr <= 32'h0000_0000;
			rr_last <= 1'b0;
		end else if (mem_clr) begin
			m_axi_arvalid <= 1'b0;
			rr_last <= 1'b0;
		end else if (m_axi_arvalid) begin
			if (m_axi_arready)
				m_axi_arvalid <= 1'b0;
		end else if (ar_issue != 2'h0) begin
			m_axi_arvalid <= 1'b1;
			m_axi_arid <= ar_issue[1] ? `RID_PREV2 : `RID_PREV1; // RULE8
			m_axi_araddr <= ar_issue[1] ? rd_addr[1] : rd_addr[0];
			rr_last <= ar_issue[1];
		end
	end

	// output pacing: two output beats owed per accepted input pixel
	reg [3:0] credit;
	reg [11:0] ox;
	reg [11:0] oy;
	wire bf_ready;
	wire osel = oy[0];
	wire beat = en && (credit != 4'h0) && has_word[osel] && bf_ready;
	wire eol = (ox == line_len - 12'h001);
	wire eof = eol && (oy == lines - 12'h001);
	assign pop_rd = {beat && osel, beat && !osel};
	assign rot_req = beat && eof; // RULE25
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			credit <= 4'h0;
			ox <= 12'h000;
			oy <= 12'h000;
			hblank <= 1'b0;
			vblank <= 1'b0;
		end else if (vid_clr) begin
			credit <= 4'h0;
			ox <= 12'h000;
			oy <= 12'h000;
			hblank <= 1'b0;
			vblank <= 1'b0;
		end else begin
			credit <= credit + ((take && en) ? `OUT_PER_IN : 4'h0) - {3'h0, beat}; // RULE16
			hblank <= beat && eol; // RULE19
			vblank <= beat && eof; // RULE19
			if (beat) begin
				ox <= eol ? 12'h000 : ox + 12'h001;
				if (eof)
					oy <= 12'h000;
				else if (eol)
					oy <= oy + 12'h001;
			end
		end
	end

	// chroma shaping: 4:2:2 drops odd-pixel chroma, 4:2:0 odd-line chroma
	reg [31:0] shaped;
	always @* begin
		shaped = rd_word[osel];
		if (fmt == `FMT_422 && ox[0])
			shaped[31:16] = 16'h0000; // RULE20
		else if (fmt == `FMT_420 && oy[0])
			shaped[31:16] = 16'h0000; // RULE20
	end

	// output words pass a two-entry buffer so a stalled receiver loses none
	wire [33:0] bf_out;
	two_slot_buffer #(
		.WIDTH(34)
	) out_buf (
		.clock(clock),
		.sys_rst(sys_rst),
		.clear(vid_clr),
		.in_valid(beat),
		.in_ready(bf_ready),
		.in_data({(ox == 12'h000) && (oy == 12'h000), eol, shaped}), // RULE19
		.out_valid(m_tvalid),
		.out_ready(m_tready),
		.out_data(bf_out)
	);
	assign m_tuser = bf_out[33];
	assign m_tlast = bf_out[32];
	assign m_tdata = bf_out[31:0];
endmodule
`default_nettype wire

// ==== verification/field_memory_port_assertions.sv ====
// checker for the memory master and video ports of the field port
// assumes one clock and sys_rst clearing every domain together
`timescale 1ns/1ps
`default_nettype none
`include "field_port_defs.vh"
module field_memory_port_assertions (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// write channels
	input wire logic [7:0] m_axi_awlen,
	input wire logic [2:0] m_axi_awsize,
	input wire logic [1:0] m_axi_awburst,
	input wire logic m_axi_awvalid,
	input wire logic m_axi_awready,
	input wire logic [3:0] m_axi_wstrb,
	input wire logic m_axi_wlast,
	input wire logic m_axi_wvalid,
	input wire logic m_axi_wready,
	input wire logic m_axi_bvalid,
	input wire logic m_axi_bready,
	// read channels
	input wire logic [7:0] m_axi_arlen,
	input wire logic [2:0] m_axi_arsize,
	input wire logic [1:0] m_axi_arburst,
	input wire logic m_axi_arid,
	input wire logic m_axi_arvalid,
	input wire logic m_axi_arready,
	input wire logic m_axi_rid,
	input wire logic m_axi_rlast,
	input wire logic m_axi_rvalid,
	input wire logic m_axi_rready,
	// video
	input wire logic s_tready
);
	logic [5:0] beats; // write beats taken in this burst
	logic open_wr; // a write awaits its response
	logic [1:0] pend [2]; // read bursts pending per id
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// follow beats, the open write and pending reads
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			beats <= 6'h00;
			open_wr <= 1'b0;
			pend[0] <= 2'h0;
			pend[1] <= 2'h0;
		end else begin
			if (m_axi_wvalid && m_axi_wready)
				beats <= m_axi_wlast ? 6'h00 : beats + 6'h01;
			if (m_axi_awvalid && m_axi_awready)
				open_wr <= 1'b1;
			else if (m_axi_bvalid)
				open_wr <= 1'b0;
			for (int n = 0; n < 2; n++)
				pend[n] <= pend[n] + {1'b0, m_axi_arvalid && m_axi_arready && m_axi_arid == n}
					- {1'b0, m_axi_rvalid && m_axi_rlast && m_axi_rid == n};
		end
	end
	sequence aw_hs;
		m_axi_awvalid && m_axi_awready;
	endsequence
	sequence w_more;
		m_axi_wvalid && !(m_axi_wready && m_axi_wlast);
	endsequence
	chk_aw_shape: assert property (m_axi_awvalid |-> m_axi_awlen == `AXLEN_FIXED && m_axi_awsize == 3'h2
		&& m_axi_awburst == `AXBURST_INCR)
		else $error("write burst shape wrong");
	chk_w_count: assert property (m_axi_wvalid && m_axi_wready |-> m_axi_wlast == (beats == 6'h1f))
		else $error("write last beat misplaced");
	chk_w_full: assert property (m_axi_wvalid |-> m_axi_wstrb == `WSTRB_ALL)
		else $error("narrow write beat");
	chk_w_nogap: assert property (w_more |=> m_axi_wvalid)
		else $error("gap inside write burst");
	chk_w_follow: assert property (aw_hs |=> m_axi_wvalid)
		else $error("write data late after address");
	chk_one_write: assert property (m_axi_awvalid |-> !open_wr)
		else $error("second write outstanding");
	chk_ar_shape: assert property (m_axi_arvalid |-> m_axi_arlen == `AXLEN_FIXED && m_axi_arsize == 3'h2
		&& m_axi_arburst == `AXBURST_INCR)
		else $error("read burst shape wrong");
	chk_rready_high: assert property (m_axi_rready && m_axi_bready)
		else $error("read ready dropped");
	chk_ar_limit: assert property (m_axi_arvalid |-> pend[m_axi_arid] < 2'h2)
		else $error("too many reads pending");
	chk_tready_high: assert property (s_tready && $stable(s_tready))
		else $error("input ready dropped");
endmodule
bind field_memory_port field_memory_port_assertions u_field_memory_port_assertions (.*);
`default_nettype wire

// ==== verification/memory_partner.sv ====
// memory behind the master: takes writes, returns reads by id
// assumes rready and bready held high by the master
`timescale 1ns/1ps
`default_nettype none
module memory_partner (
	// clock, reset and pace
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic slow,
	// write channels
	input wire logic m_axi_awvalid,
	output logic m_axi_awready,
	input wire logic m_axi_wvalid,
	input wire logic m_axi_wlast,
	output logic m_axi_wready,
	output logic [1:0] m_axi_bresp,
	output logic m_axi_bvalid,
	// read channels
	input wire logic [31:0] m_axi_araddr,
	input wire logic m_axi_arid,
	input wire logic m_axi_arvalid,
	output logic m_axi_arready,
	output logic [31:0] m_axi_rdata,
	output logic m_axi_rid,
	output logic m_axi_rlast,
	output logic m_axi_rvalid
);
	logic [31:0] q [2][$]; // pending read bases per id
	logic [4:0] bt [2]; // beat within the head burst per id
	logic tick, turn, pick; // pace toggle, id served last, id chosen
	// accept requests, answer beats, ids interleaved
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			{m_axi_awready, m_axi_wready, m_axi_bvalid, m_axi_arready, m_axi_rvalid} <= 5'h00;
			{m_axi_rid, m_axi_rlast, tick, turn} <= 4'h0;
			m_axi_rdata <= 32'h0000_0000;
			m_axi_bresp <= 2'h0;
			bt[0] <= 5'h00;
			bt[1] <= 5'h00;
			q[0].delete();
			q[1].delete();
		end else begin
			tick <= ~tick;
			m_axi_awready <= !slow || tick;
			m_axi_wready <= !slow || !tick;
			m_axi_arready <= !slow || tick;
			m_axi_bvalid <= m_axi_wvalid && m_axi_wready && m_axi_wlast;
			if (m_axi_arvalid && m_axi_arready)
				q[m_axi_arid].push_back(m_axi_araddr);
			pick = q[!turn].size() != 0 ? !turn : turn;
			if (q[pick].size() != 0 && (!slow || tick)) begin
				m_axi_rvalid <= 1'b1;
				m_axi_rid <= pick;
				m_axi_rdata <= {pick, q[pick][0][30:0] + {24'h00_0000, bt[pick], 2'b00}};
				m_axi_rlast <= bt[pick] == 5'h1f;
				bt[pick] <= bt[pick] + 5'h01;
				turn <= pick;
				if (bt[pick] == 5'h1f)
					q[pick].pop_front();
			end else begin
				// idle lines never repeat the last beat
				{m_axi_rvalid, m_axi_rlast} <= 2'h0;
				m_axi_rid <= ~m_axi_rid;
				m_axi_rdata <= ~m_axi_rdata;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verification/field_memory_port_tb.sv ====
// bench: streams pairs in, checks memory traffic and video out
// assumes the memory partner and the bound checker beside the design
`timescale 1ns/1ps
`default_nettype none
`include "field_port_defs.vh"
module field_memory_port_tb;
	// design and partner ports
	logic clock, sys_rst, video_rst_n, ctrl_rst_n, mem_rst_n, pix_clk, s_tvalid, s_tready, s_tuser, in_active;
	logic m_tvalid, m_tready, m_tuser, m_tlast, hblank, vblank, deint_en, depth_12, slow, m_axi_bready;
	logic m_axi_awvalid, m_axi_awready, m_axi_wlast, m_axi_wvalid, m_axi_wready, m_axi_bvalid, m_axi_arid;
	logic m_axi_arvalid, m_axi_arready, m_axi_rid, m_axi_rlast, m_axi_rvalid, m_axi_rready;
	logic [47:0] s_tdata;
	logic [31:0] m_tdata, m_axi_awaddr, m_axi_wdata, m_axi_araddr, m_axi_rdata;
	logic [11:0] out_line_len, out_lines;
	logic [95:0] buf_bases, acc;
	logic [7:0] m_axi_awlen, m_axi_arlen;
	logic [2:0] m_axi_awsize, m_axi_arsize;
	logic [1:0] chroma_fmt, m_axi_awburst, m_axi_arburst, m_axi_bresp;
	logic [3:0] m_axi_wstrb;
	// bench state
	int n_errors, checks, cyc, k, hb, vb, na, ln, ps;
	logic [31:0] got_w [$], exp_w [$], aw_q [$], ar_q [2][$];
	field_memory_port u_field_memory_port (.*);
	memory_partner u_memory_partner (.*);
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			n_errors++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic give_verdict;
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	function automatic logic [31:0] base(input int j);
		return buf_bases[32 * (j % 3) +: 32];
	endfunction
	// one pair per pixel clock, taken at its falling edge
	task automatic send(input logic [47:0] d, input logic act, input logic sof);
		{s_tdata, in_active, s_tuser, s_tvalid} = {d, act, sof, 1'b1};
		pix_clk = 1'b1;
		#160 pix_clk = 1'b0;
		#160;
	endtask
	// reset, stream 52 pairs, then judge memory and video traffic
	task automatic stream(input logic wide, input logic [1:0] fmt);
		logic [47:0] d;
		int i, w;
		{depth_12, chroma_fmt, sys_rst, video_rst_n, ctrl_rst_n, mem_rst_n} = {wide, fmt, 4'h8};
		// clear the tallies while reset holds, before the first read can land
		{acc, na, k, hb, vb} = 0;
		exp_w.delete();
		got_w.delete();
		aw_q.delete();
		ar_q[0].delete();
		ar_q[1].delete();
		repeat (12) @(posedge clock);
		@(negedge clock);
		{sys_rst, video_rst_n, ctrl_rst_n, mem_rst_n} = 4'h7;
		repeat (6) @(negedge clock);
		send(48'h0123_4567_89ab, 1'b1, 1'b0);
		for (i = 0; i < 52; i++) begin
			d = {i[7:0], 8'h5a, ~i[15:0], i[15:0]};
			send(d, 1'b1, i == 0);
			acc |= (wide ? 96'(d) : 96'(d[39:0])) << na;
			na += wide ? 48 : 40;
			for (; na >= 32; na -= 32) begin
				exp_w.push_back(acc[31:0]);
				acc >>= 32;
			end
			if (i % 5 == 4)
				send(~d, 1'b0, 1'b0);
		end
		@(negedge clock);
		s_tvalid = 1'b0;
		for (i = 0; i < 3000 && !(k == 104 && got_w.size() >= 64); i++)
			@(negedge clock);
		check(k, 104);
		check(hb, 6);
		check(vb, 1);
		for (i = 0; i < 64; i++)
			check(got_w[i], exp_w[i]);
		w = `BUF_FIRST;
		check(aw_q[0], base(w));
		check(aw_q[1], base(w + 1));
		check(ar_q[0][0], base(w + 2));
		check(ar_q[1][0], base(w + 1));
		check(ar_q[0][1], ar_q[0][0] + `BURST_BYTES);
	endtask
	task automatic scn_narrow_444_fast;
		slow = 1'b0;
		stream(1'b0, `FMT_444);
	endtask
	task automatic scn_wide_422_slow;
		slow = 1'b1;
		stream(1'b1, `FMT_422);
	endtask
	task automatic scn_narrow_420_slow;
		slow = 1'b1;
		stream(1'b0, `FMT_420);
	endtask
	// clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// receiver stalls every third cycle
	always @(negedge clock)
		m_tready <= cyc % 3 != 0;
	// watch memory and video ports, cut a hang short
	always @(posedge clock) begin
		cyc++;
		if (cyc == 12000) begin
			n_errors++;
			give_verdict();
		end
		if (m_axi_wvalid && m_axi_wready)
			got_w.push_back(m_axi_wdata);
		if (m_axi_awvalid && m_axi_awready)
			aw_q.push_back(m_axi_awaddr);
		if (m_axi_arvalid && m_axi_arready)
			ar_q[m_axi_arid].push_back(m_axi_araddr);
		hb += hblank;
		vb += vblank;
		if (m_tvalid && m_tready) begin
			ln = k / 16 % 4;
			ps = k % 16;
			check(m_tuser, k % 64 == 0);
			check(m_tlast, ps == 15);
			if ((chroma_fmt == `FMT_422 && ps % 2) || (chroma_fmt == `FMT_420 && ln % 2))
				check(m_tdata[31:16], 0);
			else
				check(m_tdata[31], ln % 2);
			k++;
		end
	end
	// time-zero values, then the scenarios
	initial begin
		{sys_rst, video_rst_n, ctrl_rst_n, mem_rst_n, pix_clk, s_tvalid, s_tuser, in_active} = 8'h80;
		{s_tdata, deint_en, slow, chroma_fmt, depth_12} = {48'h0, 5'h10};
		{out_line_len, out_lines} = {12'h010, 12'h004};
		buf_bases = {32'h3000_0000, 32'h2000_0000, 32'h1000_0000};
		scn_narrow_444_fast();
		scn_wide_422_slow();
		scn_narrow_420_slow();
		give_verdict();
	end
endmodule
`default_nettype wire
